/* logic/ccd_fe_pkg.sv */
// Shared constants for the CCD front-end digital link: serial word layout,
// configuration addresses, reset values and timing counts at a 200 MHz mclk.
package ccd_fe_pkg;

  localparam int         PIX_W          = 10;
  localparam int         SER_WORD_W     = 16;
  localparam int         SER_ADDR_W     = 4;
  localparam int         SER_DATA_W     = 12;
  localparam int         SER_ADDR_MSB   = 15;
  localparam int         SER_ADDR_LSB   = 12;

  localparam logic [3:0] ADDR_GAIN      = 4'h0;
  localparam logic [3:0] ADDR_DELAY     = 4'h1;
  localparam logic [3:0] ADDR_POLARITY  = 4'h2;

  // Gain code: 0 is -6 dB, full scale is 42 dB, linear in dB per step
  localparam int         GAIN_W         = 10;
  localparam logic [9:0] GAIN_RST       = 10'h000;
  localparam logic [1:0] DELAY_RST      = 2'h0;
  // Polarity bit 0 = active low; bit order ob, ref, data, dummy
  localparam logic [3:0] POL_RST        = 4'h0;
  localparam int         POL_OB         = 0;
  localparam int         POL_REF        = 1;
  localparam int         POL_DATA       = 2;
  localparam int         POL_DUMMY      = 3;

  localparam int         CLK_PERIOD_NS  = 5;
  localparam int         DLY1_NS        = 5;
  localparam int         DLY2_NS        = 10;
  localparam int         DLY3_NS        = 13;
  localparam int         DLY1_CYC       = (DLY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         DLY2_CYC       = (DLY2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         DLY3_CYC       = (DLY3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         PIPE_DEPTH     = DLY3_CYC + 1;

  localparam int         MCLK_MHZ       = 200;
  localparam int         CONV_MAX_MHZ   = 28;
  localparam int         PIX_MIN_CYC    = (MCLK_MHZ + CONV_MAX_MHZ - 1) / CONV_MAX_MHZ;
  localparam int         PIX_CYC        = 8;
  localparam logic [2:0] PH_REF_ON      = 3'h1;
  localparam logic [2:0] PH_REF_OFF     = 3'h3;
  localparam logic [2:0] PH_DATA_ON     = 3'h4;
  localparam logic [2:0] PH_DATA_OFF    = 3'h6;
  localparam logic [2:0] PH_CONV_LOW    = 3'h4;
  localparam logic [2:0] PH_CAPTURE     = 3'h7;
  localparam logic [2:0] PH_LAST        = 3'h7;

  localparam int         LINE_PIX       = 16;
  localparam logic [3:0] OB_FIRST       = 4'h0;
  localparam logic [3:0] OB_LAST        = 4'h1;
  localparam logic [3:0] DUMMY_PIX      = 4'h2;
  localparam logic [3:0] BLANK_FIRST    = 4'he;

  localparam logic [1:0] SCLK_RISE      = 2'h2;
  localparam logic [4:0] SER_BITS       = 5'h10;

endpackage

/* logic/ccd_fe_link_if.sv */
// Pin-level link between the front end and its timing generator.
// All pins are plain one-way logic levels sampled on mclk, except dev_reset_n, which resets the front end without the clock.
`timescale 1ns/100ps
interface ccd_fe_link_if;
  import ccd_fe_pkg::*;

  logic [PIX_W-1:0] pix_out;
  logic             conv_clk;
  logic             preblank_n;
  logic             ob_clamp_pulse;
  logic             ref_sample_pulse;
  logic             data_sample_pulse;
  logic             dummy_clamp_pulse;
  logic             dev_reset_n;
  logic             ser_clk;
  logic             ser_din;
  logic             ser_latch;

  modport dev (
    output pix_out,
    input  conv_clk, preblank_n, ob_clamp_pulse, ref_sample_pulse, data_sample_pulse,
    input  dummy_clamp_pulse, dev_reset_n, ser_clk, ser_din, ser_latch
  );

  modport tg (
    input  pix_out,
    output conv_clk, preblank_n, ob_clamp_pulse, ref_sample_pulse, data_sample_pulse,
    output dummy_clamp_pulse, dev_reset_n, ser_clk, ser_din, ser_latch
  );
endinterface

/* logic/ccd_fe_device.sv */
// Digital side of the CCD front end: serial configuration, pulse decode,
// two-entry pixel buffer and delayed, blankable 10-bit output.
// Assumes link pins are synchronous to mclk; converter result arrives on adc_code.
`timescale 1ns/100ps
module ccd_fe_device
(
  input  wire logic                           mclk,
  input  wire logic                           reset,
  ccd_fe_link_if.dev                          link,
  input  wire logic [ccd_fe_pkg::PIX_W-1:0]   adc_code,
  output logic      [ccd_fe_pkg::GAIN_W-1:0]  gain_code,
  output logic      [1:0]                     out_delay,
  output logic                                ob_clamp_en,
  output logic                                ref_sample_en,
  output logic                                data_sample_en,
  output logic                                dummy_clamp_en,
  output logic                                pix_buf_ready,
  output logic                                pix_overflow
);
  import ccd_fe_pkg::*;

  typedef struct packed {
    logic                              conv_q;
    logic                              sclk_q;
    logic                              latch_q;
    logic                              data_act_q;
    logic [SER_WORD_W-1:0]             shift;
    logic [GAIN_W-1:0]                 gain;
    logic [1:0]                        delay;
    logic [3:0]                        pol;
    logic [1:0][PIX_W-1:0]             buffer;
    logic [1:0]                        count;
    logic                              wr_ptr;
    logic                              rd_ptr;
    logic [PIPE_DEPTH-1:0][PIX_W-1:0]  pipe;
    logic [PIX_W-1:0]                  out;
    logic                              overflow;
  } dev_state_type;

  localparam dev_state_type STATE_RST = '{
    conv_q:     1'b0,
    sclk_q:     1'b0,
    latch_q:    1'b0,
    data_act_q: 1'b0,
    shift:      '0,
    gain:       GAIN_RST,
    delay:      DELAY_RST,
    pol:        POL_RST,
    buffer:     '0,
    count:      2'h0,
    wr_ptr:     1'b0,
    rd_ptr:     1'b0,
    pipe:       '0,
    out:        '0,
    overflow:   1'b0
  };

  dev_state_type state_ff;
  dev_state_type nxt_state;

  logic ob_act;
  logic ref_act;
  logic data_act;
  logic dummy_act;
  logic push;
  logic pop;
  logic [SER_ADDR_W-1:0] wr_addr;
  logic [SER_DATA_W-1:0] wr_data;

  // Pulse decode, polarity bit low means active low
  always_comb
  begin
    ob_act    = state_ff.pol[POL_OB]    ? link.ob_clamp_pulse    : ~link.ob_clamp_pulse;
    ref_act   = state_ff.pol[POL_REF]   ? link.ref_sample_pulse  : ~link.ref_sample_pulse;
    data_act  = state_ff.pol[POL_DATA]  ? link.data_sample_pulse : ~link.data_sample_pulse;
    dummy_act = state_ff.pol[POL_DUMMY] ? link.dummy_clamp_pulse : ~link.dummy_clamp_pulse;
  end

  assign ob_clamp_en    = ob_act;
  assign ref_sample_en  = ref_act;
  assign data_sample_en = data_act;
  assign dummy_clamp_en = dummy_act;

  assign wr_addr = state_ff.shift[SER_ADDR_MSB:SER_ADDR_LSB];
  assign wr_data = state_ff.shift[SER_DATA_W-1:0];

  // word taken when the data sample window closes
  assign push = state_ff.data_act_q & ~data_act;
  // one word per conversion clock rise
  assign pop  = link.conv_clk & ~state_ff.conv_q & (state_ff.count != 2'h0);

  always_comb
  begin
    nxt_state            = state_ff;
    nxt_state.conv_q     = link.conv_clk;
    nxt_state.sclk_q     = link.ser_clk;
    nxt_state.latch_q    = link.ser_latch;
    nxt_state.data_act_q = data_act;

    // shift on serial clock rise, MSB first
    if (link.ser_clk && !state_ff.sclk_q)
    begin
      nxt_state.shift = {state_ff.shift[SER_WORD_W-2:0], link.ser_din};
    end

    if (link.ser_latch && !state_ff.latch_q)
    begin
      case (wr_addr)
        // gain code, -6 dB at zero
        ADDR_GAIN:     nxt_state.gain  = wr_data[GAIN_W-1:0];
        ADDR_DELAY:    nxt_state.delay = wr_data[1:0];
        ADDR_POLARITY: nxt_state.pol   = wr_data[3:0];
        default:       nxt_state.pol   = state_ff.pol;
      endcase
    end

    // Two-entry buffer; a full buffer with no pop in the same cycle drops the new word and flags it
    if (push && (state_ff.count != 2'h2 || pop))
    begin
      nxt_state.buffer[state_ff.wr_ptr] = adc_code;
      nxt_state.wr_ptr                  = ~state_ff.wr_ptr;
    end
    if (push && state_ff.count == 2'h2 && !pop)
    begin
      nxt_state.overflow = 1'b1;
    end
    if (pop)
    begin
      nxt_state.rd_ptr = ~state_ff.rd_ptr;
    end
    case ({push && (state_ff.count != 2'h2 || pop), pop})
      2'b10:   nxt_state.count = state_ff.count + 2'h1;
      2'b01:   nxt_state.count = state_ff.count - 2'h1;
      default: nxt_state.count = state_ff.count;
    endcase

    // Stage 0 holds the current word; later stages add one mclk each
    // new word loaded on each conversion clock rise that finds the buffer not empty
    if (pop)
    begin
      nxt_state.pipe[0] = state_ff.buffer[state_ff.rd_ptr];
    end
    for (int i = 1; i < PIPE_DEPTH; i++)
    begin
      nxt_state.pipe[i] = state_ff.pipe[i-1];
    end

    // extra delay taken from a deeper stage
    case (state_ff.delay)
      2'h0:    nxt_state.out = state_ff.pipe[0];
      2'h1:    nxt_state.out = state_ff.pipe[DLY1_CYC];
      2'h2:    nxt_state.out = state_ff.pipe[DLY2_CYC];
      2'h3:    nxt_state.out = state_ff.pipe[DLY3_CYC];
      default: nxt_state.out = state_ff.pipe[0];
    endcase
    if (!link.preblank_n)
    begin
      nxt_state.out = '0;
    end
  end

  // reset pin acts without the clock
  always_ff @(posedge mclk or negedge link.dev_reset_n)
  begin
    if (!link.dev_reset_n)
    begin
      state_ff <= STATE_RST;
    end
    else if (reset)
    begin
      state_ff <= STATE_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // bit 0 is the LSB line, bit 9 the MSB line
  assign link.pix_out   = state_ff.out;
  assign gain_code      = state_ff.gain;
  assign out_delay      = state_ff.delay;
  assign pix_buf_ready  = (state_ff.count != 2'h2);
  assign pix_overflow   = state_ff.overflow;

endmodule

/* logic/ccd_fe_timing_gen.sv */
// Timing generator end: makes the conversion clock, per-pixel sampling and
// clamp pulses, preblanking, device reset and serial configuration writes.
// Assumes the front end samples all pins on the same mclk.
`timescale 1ns/100ps
module ccd_fe_timing_gen
(
  input  wire logic                               mclk,
  input  wire logic                               reset,
  ccd_fe_link_if.tg                               link,
  input  wire logic                               cfg_valid,
  output logic                                    cfg_ready,
  input  wire logic [ccd_fe_pkg::SER_ADDR_W-1:0]  cfg_addr,
  input  wire logic [ccd_fe_pkg::SER_DATA_W-1:0]  cfg_data,
  input  wire logic                               blank_req,
  output logic      [ccd_fe_pkg::PIX_W-1:0]       pix_word,
  output logic                                    pix_valid
);
  import ccd_fe_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_LATCH} ser_state_type;

  typedef struct packed {
    ser_state_type          ser;
    logic [2:0]             phase;
    logic [3:0]             pix_idx;
    logic [SER_WORD_W-1:0]  shift;
    logic [4:0]             bits;
    logic [1:0]             div;
    logic [3:0]             pol;
    logic [3:0]             pol_new;
    logic                   pol_pend;
    logic                   rst_n;
    logic [PIX_W-1:0]       word;
    logic                   valid;
  } tg_state_type;

  localparam tg_state_type STATE_RST = '{
    ser:     S_IDLE,
    phase:   3'h0,
    pix_idx: 4'h0,
    shift:   '0,
    bits:    5'h0,
    div:     2'h0,
    pol:     POL_RST,
    pol_new: POL_RST,
    pol_pend: 1'b0,
    rst_n:   1'b0,
    word:    '0,
    valid:   1'b0
  };

  tg_state_type state_ff;
  tg_state_type nxt_state;

  logic ref_on;
  logic data_on;
  logic ob_on;
  logic dummy_on;

  always_comb
  begin
    nxt_state       = state_ff;
    nxt_state.rst_n = 1'b1;
    nxt_state.valid = 1'b0;

    // pixel period at or below the 28 MHz ceiling
    nxt_state.phase = (state_ff.phase == PH_LAST) ? 3'h0 : state_ff.phase + 3'h1;
    if (state_ff.phase == PH_LAST)
    begin
      nxt_state.pix_idx = state_ff.pix_idx + 4'h1;
    end
    if (state_ff.phase == PH_CAPTURE)
    begin
      nxt_state.word  = link.pix_out;
      nxt_state.valid = 1'b1;
    end

    case (state_ff.ser)
      S_IDLE:
      begin
        if (cfg_valid)
        begin
          nxt_state.shift = {cfg_addr, cfg_data};
          nxt_state.bits  = 5'h0;
          nxt_state.div   = 2'h0;
          nxt_state.ser   = S_SHIFT;
          // new polarity waits for the latch, as the front end does
          nxt_state.pol_new  = cfg_data[3:0];
          nxt_state.pol_pend = (cfg_addr == ADDR_POLARITY);
        end
      end
      S_SHIFT:
      begin
        nxt_state.div = state_ff.div + 2'h1;
        // data changes only after the high phase ends
        if (state_ff.div == 2'h3)
        begin
          nxt_state.shift = {state_ff.shift[SER_WORD_W-2:0], 1'b0};
          nxt_state.bits  = state_ff.bits + 5'h1;
          if (state_ff.bits == SER_BITS - 5'h1)
          begin
            nxt_state.ser = S_LATCH;
          end
        end
      end
      S_LATCH:
      begin
        // latch raised after the last bit
        nxt_state.div = state_ff.div + 2'h1;
        // Switch on the front end's commit edge so no pin runs inverted
        if (state_ff.div == SCLK_RISE && state_ff.pol_pend)
        begin
          nxt_state.pol = state_ff.pol_new;
        end
        if (state_ff.div == 2'h3)
        begin
          nxt_state.ser = S_IDLE;
        end
      end
      default: nxt_state.ser = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_ff <= STATE_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign ref_on   = (state_ff.phase >= PH_REF_ON) && (state_ff.phase < PH_REF_OFF);
  // data pulse after the reference pulse
  assign data_on  = (state_ff.phase >= PH_DATA_ON) && (state_ff.phase < PH_DATA_OFF);
  assign ob_on    = (state_ff.pix_idx >= OB_FIRST) && (state_ff.pix_idx <= OB_LAST);
  assign dummy_on = (state_ff.pix_idx == DUMMY_PIX);

  // drive each pulse in the polarity last written
  assign link.ob_clamp_pulse    = state_ff.pol[POL_OB]    ? ob_on    : ~ob_on;
  assign link.ref_sample_pulse  = state_ff.pol[POL_REF]   ? ref_on   : ~ref_on;
  assign link.data_sample_pulse = state_ff.pol[POL_DATA]  ? data_on  : ~data_on;
  assign link.dummy_clamp_pulse = state_ff.pol[POL_DUMMY] ? dummy_on : ~dummy_on;

  assign link.conv_clk    = (state_ff.phase < PH_CONV_LOW);
  // blank tail of the line or on request
  assign link.preblank_n  = ~(blank_req || (state_ff.pix_idx >= BLANK_FIRST));
  // device held in reset with this end
  assign link.dev_reset_n = state_ff.rst_n;
  assign link.ser_clk     = (state_ff.ser == S_SHIFT) && (state_ff.div >= SCLK_RISE);
  assign link.ser_din     = state_ff.shift[SER_WORD_W-1];
  assign link.ser_latch   = (state_ff.ser == S_LATCH) && (state_ff.div >= SCLK_RISE);
  assign cfg_ready        = (state_ff.ser == S_IDLE);
  assign pix_word         = state_ff.word;
  assign pix_valid        = state_ff.valid;

endmodule

/* tb/ccd_fe_link_checker.sv */
// Concurrent checks on the pins between front end and timing generator.
// Assumes every pin is synchronous to mclk; instantiated beside the link.
`timescale 1ns/100ps
module ccd_fe_link_checker
(
  input wire logic                         mclk,
  input wire logic                         reset,
  input wire logic [ccd_fe_pkg::PIX_W-1:0] pix_out,
  input wire logic                         conv_clk,
  input wire logic                         preblank_n,
  input wire logic                         ref_sample_pulse,
  input wire logic                         data_sample_pulse,
  input wire logic                         dev_reset_n,
  input wire logic                         ser_clk,
  input wire logic                         ser_din,
  input wire logic                         ser_latch
);
  import ccd_fe_pkg::*;

  logic [4:0] sclk_cnt_ff;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Serial clock rises since the last latch
  always_ff @(posedge mclk)
  begin
    if (reset)
      sclk_cnt_ff <= 5'h00;
    else if ($rose(ser_latch))
      sclk_cnt_ff <= 5'h00;
    else if ($rose(ser_clk))
      sclk_cnt_ff <= sclk_cnt_ff + 5'h01;
  end

  sequence ref_pulse_s;
    $changed(ref_sample_pulse) ##2 $changed(ref_sample_pulse);
  endsequence

  sequence data_pulse_s;
    $changed(data_sample_pulse) ##2 $changed(data_sample_pulse);
  endsequence

  AST_BLANK_ZERO: assert property (!preblank_n |=> pix_out == 10'h000)
    else $error("pix_out not zero while blanked");
  AST_CONV_PERIOD: assert property ($rose(conv_clk) |=> conv_clk[*3] ##1 !conv_clk[*4] ##1 conv_clk)
    else $error("conversion clock period wrong");
  AST_PULSE_ORDER: assert property ($rose(conv_clk) |=> ref_pulse_s ##1 data_pulse_s)
    else $error("sampling pulses out of order");
  AST_SCLK_HIGH: assert property ($rose(ser_clk) |=> ser_clk ##1 !ser_clk)
    else $error("serial clock high time wrong");
  AST_SDIN_STABLE: assert property ($rose(ser_clk) |-> $stable(ser_din) ##1 $stable(ser_din))
    else $error("serial data moved at clock rise");
  AST_LATCH_COUNT: assert property ($rose(ser_latch) |-> sclk_cnt_ff == 5'h10)
    else $error("latch before sixteen bits");
  AST_LATCH_WIDTH: assert property ($rose(ser_latch) |-> !ser_clk throughout ser_latch[*2] ##1 !ser_latch)
    else $error("latch pulse shape wrong");
  AST_RST_RELEASE: assert property ($fell(reset) |-> ##[1:2] dev_reset_n)
    else $error("device reset not released");
endmodule

/* tb/testbench.sv */
// Self-checking bench: timing generator and front end joined by the link.
// Drives the generator's user side and the converter code at mclk fall.
`timescale 1ns/100ps
module testbench;
  import ccd_fe_pkg::*;
  logic                  mclk;
  logic                  reset;
  logic [PIX_W-1:0]      adc_code;
  logic                  cfg_valid;
  logic                  cfg_ready;
  logic [SER_ADDR_W-1:0] cfg_addr;
  logic [SER_DATA_W-1:0] cfg_data;
  logic                  blank_req;
  logic [PIX_W-1:0]      pix_word;
  logic                  pix_valid;
  logic [GAIN_W-1:0]     gain_code;
  logic [1:0]            out_delay;
  logic                  ob_clamp_en;
  logic                  ref_sample_en;
  logic                  data_sample_en;
  logic                  dummy_clamp_en;
  logic                  pix_buf_ready;
  logic                  pix_overflow;
  int                    bad_count;
  int                    n_tests;

  ccd_fe_link_if i_ccd_fe_link_if ();
  ccd_fe_device i_ccd_fe_device (.mclk(mclk), .reset(reset), .link(i_ccd_fe_link_if.dev), .adc_code(adc_code),
    .gain_code(gain_code), .out_delay(out_delay), .ob_clamp_en(ob_clamp_en), .ref_sample_en(ref_sample_en),
    .data_sample_en(data_sample_en), .dummy_clamp_en(dummy_clamp_en), .pix_buf_ready(pix_buf_ready),
    .pix_overflow(pix_overflow));
  ccd_fe_timing_gen i_ccd_fe_timing_gen (.mclk(mclk), .reset(reset), .link(i_ccd_fe_link_if.tg),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
    .blank_req(blank_req), .pix_word(pix_word), .pix_valid(pix_valid));
  ccd_fe_link_checker i_ccd_fe_link_checker (.mclk(mclk), .reset(reset), .pix_out(i_ccd_fe_link_if.pix_out),
    .conv_clk(i_ccd_fe_link_if.conv_clk), .preblank_n(i_ccd_fe_link_if.preblank_n),
    .ref_sample_pulse(i_ccd_fe_link_if.ref_sample_pulse), .data_sample_pulse(i_ccd_fe_link_if.data_sample_pulse),
    .dev_reset_n(i_ccd_fe_link_if.dev_reset_n), .ser_clk(i_ccd_fe_link_if.ser_clk),
    .ser_din(i_ccd_fe_link_if.ser_din), .ser_latch(i_ccd_fe_link_if.ser_latch));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One serial write; the request is held until the edge that takes it
  task automatic cfg_write(input logic [3:0] a, input logic [11:0] d);
    int k;
    k = 0;
    while (cfg_ready !== 1'b1 && k < 200)
    begin
      @(negedge mclk);
      k++;
    end
    cfg_valid = 1'b1;
    cfg_addr = a;
    cfg_data = d;
    @(negedge mclk);
    cfg_valid = 1'b0;
    k = 0;
    while (cfg_ready !== 1'b1 && k < 200)
    begin
      @(negedge mclk);
      k++;
    end
    chk("cfg busy span", k > 60 && k < 75, 1'b1);
    repeat (2) @(negedge mclk);
  endtask

  task automatic t_reset_vals();
    chk("gain after reset", gain_code, GAIN_RST);
    chk("delay after reset", out_delay, DELAY_RST);
    chk("overflow after reset", pix_overflow, 1'b0);
    chk("pix_out after reset", i_ccd_fe_link_if.pix_out, 10'h000);
  endtask

  task automatic t_config();
    cfg_write(ADDR_GAIN, 12'h3ff);
    chk("gain full scale", gain_code, 10'h3ff);
    cfg_write(ADDR_GAIN, 12'h155);
    chk("gain rewrite", gain_code, 10'h155);
    cfg_write(4'h5, 12'h2aa);
    chk("gain kept", gain_code, 10'h155);
    cfg_write(ADDR_DELAY, 12'h002);
    chk("delay write", out_delay, 2'h2);
    chk("gain still kept", gain_code, 10'h155);
    reset = 1'b1;
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
    t_reset_vals();
  endtask

  // Output latency after each conversion clock rise, measured on pixels clear of blanking
  task automatic t_delay(input logic [1:0] d);
    logic [PIX_W-1:0] last;
    logic             bl;
    logic             prev_bl;
    int               k;
    cfg_write(ADDR_DELAY, {10'h000, d});
    chk("delay code", out_delay, d);
    adc_code = 10'h2aa;
    prev_bl = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge i_ccd_fe_link_if.conv_clk);
      @(negedge mclk);
      bl = i_ccd_fe_link_if.preblank_n;
      adc_code = ~adc_code;
      last = i_ccd_fe_link_if.pix_out;
      k = 0;
      // Gives up inside the pixel so the next conv_clk rise is never missed
      while (i_ccd_fe_link_if.pix_out === last && k < 7)
      begin
        @(negedge mclk);
        k++;
      end
      if (bl === 1'b1 && prev_bl === 1'b1 && i_ccd_fe_link_if.preblank_n === 1'b1)
        chk("pix_out latency", k, 2 + d);
      prev_bl = bl;
    end
  endtask

  // One full line of 16 pixels: words, blanking, pulse windows, clamp polarity
  task automatic t_line(input logic blank, input int nz, input int nw, input int npol);
    int nv = 0, z = 0, w = 0, nref = 0, ndat = 0, nob = 0, ndum = 0, both = 0, ovf = 0, pol = 0;
    // Not symmetric, so a reversed bus cannot pass
    adc_code = 10'h203;
    blank_req = blank;
    repeat (32) @(negedge mclk);
    repeat (128)
    begin
      @(negedge mclk);
      nv += pix_valid;
      z += (pix_valid && pix_word === 10'h000);
      w += (pix_valid && pix_word === 10'h203);
      nref += ref_sample_en;
      ndat += data_sample_en;
      nob += ob_clamp_en;
      ndum += dummy_clamp_en;
      both += (ob_clamp_en && dummy_clamp_en);
      ovf += (pix_overflow || !pix_buf_ready);
      // Decode follows the pin when active high, inverts it when active low
      pol += (ob_clamp_en === i_ccd_fe_link_if.ob_clamp_pulse);
      pol += (dummy_clamp_en === i_ccd_fe_link_if.dummy_clamp_pulse);
    end
    chk("words per line", nv, 16);
    chk("blank words", z, nz);
    chk("bit order words", w, nw);
    chk("ref window cycles", nref, 32);
    chk("data window cycles", ndat, 32);
    chk("ob clamp seen", nob > 0, 1'b1);
    chk("dummy clamp seen", ndum > 0, 1'b1);
    chk("clamps overlap", both, 0);
    chk("buffer trouble", ovf, 0);
    chk("clamp decode polarity", pol, npol);
    blank_req = 1'b0;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    final_report();
  end

  initial
  begin
    reset = 1'b1;
    adc_code = 10'h201;
    cfg_valid = 1'b0;
    cfg_addr = 4'h0;
    cfg_data = 12'h000;
    blank_req = 1'b0;
    bad_count = 0;
    n_tests = 0;
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    t_reset_vals();
    t_config();
    for (int d = 0; d < 4; d++)
      t_delay(d[1:0]);
    t_line(1'b0, 2, 14, 0);
    t_line(1'b1, 16, 0, 0);
    // Flip only the clamp polarities so sampling pulse order stays checkable
    cfg_write(ADDR_POLARITY, 12'h009);
    t_line(1'b0, 2, 14, 256);
    final_report();
  end
endmodule
